// File: src/ppcx_top.v
// port pin configuration and crossbar gating, top level
//
// How it works
// - input-mode bit one means digital input, zero means analog input.
// - analog pins lose pullup, output driver and digital receiver.
// - after reset every pin is a digital input.
// - output-mode bit picks open-drain or push-pull, also for peripherals.
// - bus data and clock pins are always open-drain.
// - pullup on open-drain pins while pullup-disable is zero.
// - pullup off on any pin driving low.
// - crossbar enable one routes peripherals per both assign registers.
// - crossbar off means plain port pins in input mode.
// - all output drivers off while the crossbar is off.
// - skipped pins are passed over by the crossbar.
// - pin-out follows a fixed priority decode.
// - digital-input pins still reach analog peripherals.
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "ppcx_defs.vh"
module ppcx_top
(
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// peripheral side
	input wire [7:0] periph_out,
	input wire [7:0] periph_oe,
	output reg [7:0] periph_in,
	// pins
	input wire [15:0] pin_in,
	output reg [15:0] pin_out,
	output reg [15:0] pin_oe,
	output reg [15:0] pin_pullup,
	// analog path and digital port receive
	output reg [15:0] analog_in,
	output reg [15:0] port_in
);
	wire [15:0] imode;
	wire [15:0] latch;
	wire [15:0] omode;
	wire [15:0] skip;
	wire [7:0] asg0;
	wire [7:0] asg1;
	wire [15:0] taken;
	wire [63:0] pin_sel;
	wire xbar_on;
	wire weak_pullup_disable;
	wire [7:0] periph_req;
	reg [15:0] drv_val_d;
	reg [15:0] drv_en_d;
	reg [15:0] pull_d;
	reg [15:0] rx_d;
	reg [7:0] pin_per_in_d;
	reg [15:0] open_drain;
	reg [3:0] sel;
	reg v;
	reg e;
	integer i;
	integer j;

	ppcx_apb_regs u_regs
	(
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pstrb(pstrb),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.pin_state(port_in),
		.pin_taken(taken),
		.port_input_mode_reg(imode),
		.port_latch_reg(latch),
		.port_output_mode_reg(omode),
		.port_skip_reg(skip),
		.crossbar_assign_0(asg0),
		.crossbar_assign_1(asg1)
	);

	// crossbar control bits
	assign xbar_on = asg1[`PPCX_A1_CROSSBAR_ENABLE_BIT];
	assign weak_pullup_disable = asg1[`PPCX_A1_WEAK_PULLUP_DISABLE];
	assign periph_req = {asg1[1:0], asg0[5:0]};

	ppcx_route u_route
	(
		.enable(xbar_on),
		.periph_req(periph_req),
		.skip(skip),
		.taken(taken),
		.pin_sel(pin_sel)
	);

	// per-pin drive, pullup and receive decisions
	always @*
	begin
		drv_val_d = 16'h0000;
		drv_en_d = 16'h0000;
		pull_d = 16'h0000;
		rx_d = 16'h0000;
		open_drain = 16'h0000;
		sel = 4'h0;
		v = 1'b0;
		e = 1'b0;
		for (i = 0; i < `PPCX_NPINS; i = i + 1)
		begin
			sel = pin_sel[i*4 +: 4];
			if (taken[i])
			begin
				v = periph_out[sel[2:0]];
				e = periph_oe[sel[2:0]];
				// bus data and clock forced open-drain
				open_drain[i] = ~omode[i]
					| (sel == `PPCX_PER_SDA)
					| (sel == `PPCX_PER_SCL);
			end
			else
			begin
				v = latch[i];
				e = 1'b1;
				open_drain[i] = ~omode[i];
			end
			if (imode[i] && xbar_on)
			begin
				if (open_drain[i])
				begin
					drv_en_d[i] = e & ~v;
					drv_val_d[i] = 1'b0;
				end
				else
				begin
					drv_en_d[i] = e;
					drv_val_d[i] = v;
				end
			end
			// weak pullup on open-drain, off when driving low
			pull_d[i] = imode[i] & open_drain[i] & ~weak_pullup_disable
				& ~(drv_en_d[i] & ~drv_val_d[i]);
			rx_d[i] = imode[i] & pin_in[i];
		end
	end

	// peripheral inputs from their assigned pins
	always @*
	begin
		pin_per_in_d = 8'h00;
		for (j = 0; j < `PPCX_NPINS; j = j + 1)
		begin
			if (taken[j])
				pin_per_in_d[pin_sel[j*4 +: 3]] = rx_d[j];
		end
	end

	// registered pin and receive outputs, reset to digital input
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_out <= 16'h0000;
			pin_oe <= 16'h0000;
			pin_pullup <= 16'h0000;
			port_in <= 16'h0000;
			periph_in <= 8'h00;
			analog_in <= 16'h0000;
		end
		else
		begin
			pin_out <= drv_val_d;
			pin_oe <= drv_en_d;
			pin_pullup <= pull_d;
			port_in <= rx_d;
			periph_in <= pin_per_in_d;
			analog_in <= pin_in;
		end
	end
endmodule

// File: src/ppcx_defs.vh
// register offsets, field positions, reset values for the port crossbar
`ifndef PPCX_DEFS_VH
`define PPCX_DEFS_VH
`define PPCX_NPINS 16
`define PPCX_NPERIPH 8
`define PPCX_OFS_INPUT_MODE 12'h000
`define PPCX_OFS_LATCH 12'h004
`define PPCX_OFS_OUTPUT_MODE 12'h008
`define PPCX_OFS_SKIP 12'h00c
`define PPCX_OFS_ASSIGN0 12'h010
`define PPCX_OFS_ASSIGN1 12'h014
`define PPCX_OFS_PIN_STATE 12'h018
`define PPCX_OFS_ROUTE_STATE 12'h01c
`define PPCX_RST_INPUT_MODE 16'hffff
`define PPCX_RST_LATCH 16'hffff
`define PPCX_RST_OUTPUT_MODE 16'h0000
`define PPCX_RST_SKIP 16'h0000
`define PPCX_RST_ASSIGN0 8'h00
`define PPCX_RST_ASSIGN1 8'h00
`define PPCX_A1_WEAK_PULLUP_DISABLE 7
`define PPCX_A1_CROSSBAR_ENABLE_BIT 6
`define PPCX_PER_SDA 0
`define PPCX_PER_SCL 1
`endif

// File: src/ppcx_apb_regs.v
// apb slave holding the port and crossbar configuration registers
`timescale 1ns/100ps
`include "ppcx_defs.vh"
module ppcx_apb_regs
(
	// apb
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// state readback
	input wire [15:0] pin_state,
	input wire [15:0] pin_taken,
	// configuration
	output reg [15:0] port_input_mode_reg,
	output reg [15:0] port_latch_reg,
	output reg [15:0] port_output_mode_reg,
	output reg [15:0] port_skip_reg,
	output reg [7:0] crossbar_assign_0,
	output reg [7:0] crossbar_assign_1
);
	wire wr_en;
	wire hit;
	// merge byte lanes of a 16-bit register
	function [15:0] lane16;
		input [15:0] old;
		input [31:0] wd;
		input [3:0] st;
		begin
			lane16[7:0] = st[0] ? wd[7:0] : old[7:0];
			lane16[15:8] = st[1] ? wd[15:8] : old[15:8];
		end
	endfunction
	assign pready = 1'b1;
	assign hit = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'b00);
	assign pslverr = psel & penable & ~hit;
	assign wr_en = psel & penable & pwrite & hit;
	// register writes
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			port_input_mode_reg <= `PPCX_RST_INPUT_MODE;
			port_latch_reg <= `PPCX_RST_LATCH;
			port_output_mode_reg <= `PPCX_RST_OUTPUT_MODE;
			port_skip_reg <= `PPCX_RST_SKIP;
			crossbar_assign_0 <= `PPCX_RST_ASSIGN0;
			crossbar_assign_1 <= `PPCX_RST_ASSIGN1;
		end
		else if (wr_en)
		begin
			case (paddr)
			`PPCX_OFS_INPUT_MODE:
				port_input_mode_reg <= lane16(port_input_mode_reg,
					pwdata, pstrb);
			`PPCX_OFS_LATCH:
				port_latch_reg <= lane16(port_latch_reg, pwdata, pstrb);
			`PPCX_OFS_OUTPUT_MODE:
				port_output_mode_reg <= lane16(port_output_mode_reg,
					pwdata, pstrb);
			`PPCX_OFS_SKIP:
				port_skip_reg <= lane16(port_skip_reg, pwdata, pstrb);
			`PPCX_OFS_ASSIGN0:
				if (pstrb[0])
					crossbar_assign_0 <= pwdata[7:0];
			`PPCX_OFS_ASSIGN1:
				if (pstrb[0])
					crossbar_assign_1 <= pwdata[7:0];
			default:
				port_skip_reg <= port_skip_reg;
			endcase
		end
	end
	// registered read data
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel & ~penable & ~pwrite)
		begin
			case (paddr)
			`PPCX_OFS_INPUT_MODE: prdata <= {16'h0000, port_input_mode_reg};
			`PPCX_OFS_LATCH: prdata <= {16'h0000, port_latch_reg};
			`PPCX_OFS_OUTPUT_MODE: prdata <= {16'h0000, port_output_mode_reg};
			`PPCX_OFS_SKIP: prdata <= {16'h0000, port_skip_reg};
			`PPCX_OFS_ASSIGN0: prdata <= {24'h00_0000, crossbar_assign_0};
			`PPCX_OFS_ASSIGN1: prdata <= {24'h00_0000, crossbar_assign_1};
			`PPCX_OFS_PIN_STATE: prdata <= {16'h0000, pin_state};
			`PPCX_OFS_ROUTE_STATE: prdata <= {16'h0000, pin_taken};
			default: prdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule

// File: src/ppcx_route.v
// fixed priority crossbar: peripheral signals to free, unskipped pins
`timescale 1ns/100ps
`include "ppcx_defs.vh"
module ppcx_route
(
	// configuration
	input wire enable,
	input wire [7:0] periph_req,
	input wire [15:0] skip,
	// mapping
	output reg [15:0] taken,
	output reg [63:0] pin_sel
);
	integer p;
	integer n;
	reg placed;
	// walk peripherals in order, each takes lowest free pin
	always @*
	begin
		taken = 16'h0000;
		pin_sel = 64'h0000_0000_0000_0000;
		placed = 1'b0;
		for (p = 0; p < `PPCX_NPERIPH; p = p + 1)
		begin
			placed = 1'b0;
			for (n = 0; n < `PPCX_NPINS; n = n + 1)
			begin
				if (enable && periph_req[p] && !placed && !skip[n]
					&& !taken[n])
				begin
					taken[n] = 1'b1;
					pin_sel[n*4 +: 4] = p[3:0];
					placed = 1'b1;
				end
			end
		end
	end
endmodule

// File: bench/ppcx_chk.sv
// concurrent checks on the port crossbar top level ports
`timescale 1ns/100ps
module ppcx_chk
(
	// clock, reset and apb
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic pready,
	input logic pslverr,
	// pins and peripherals
	input logic [7:0] periph_in,
	input logic [15:0] pin_in,
	input logic [15:0] pin_out,
	input logic [15:0] pin_oe,
	input logic [15:0] pin_pullup,
	input logic [15:0] analog_in,
	input logic [15:0] port_in
);
	logic [15:0] im_q, lt_q, om_q;
	logic [7:0] a0_q, a1_q;
	wire xbe = a1_q[6];
	wire wpd = a1_q[7];
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// configuration mirror; assumes full-word writes
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			im_q <= 16'hffff;
			lt_q <= 16'hffff;
			om_q <= 16'h0000;
			a0_q <= 8'h00;
			a1_q <= 8'h00;
		end
		else if (psel & penable & pwrite & pready & ~pslverr)
			case (paddr)
			12'h000: im_q <= pwdata[15:0];
			12'h004: lt_q <= pwdata[15:0];
			12'h008: om_q <= pwdata[15:0];
			12'h010: a0_q <= pwdata[7:0];
			12'h014: a1_q <= pwdata[7:0];
			default: ;
			endcase
	end
	a_oe_off_xbar: assert property (
		!xbe |=> pin_oe == 16'h0000) else $error("driver while off");
	a_analog_quiet: assert property (
		presetn |=> ((pin_oe | pin_pullup | port_in) & ~$past(im_q))
		== 16'h0000)
		else $error("analog pin active");
	a_digital_recv: assert property (
		presetn |=> port_in == ($past(pin_in) & $past(im_q)))
		else $error("receive wrong");
	a_pullup_low: assert property (
		(pin_pullup & pin_oe & ~pin_out) == 16'h0000)
		else $error("pullup on low pin");
	a_pullup_policy: assert property (
		presetn |=> (~$past(om_q) & $past(im_q) & ~(pin_oe & ~pin_out)
		& (pin_pullup ^ {16{~$past(wpd)}})) == 16'h0000)
		else $error("pullup wrong");
	a_od_no_high: assert property (
		presetn |=> (pin_oe & pin_out & ~$past(om_q)) == 16'h0000)
		else $error("open-drain high");
	a_xbar_off_in: assert property (
		!xbe |=> periph_in == 8'h00) else $error("routed while off");
	a_latch_drive: assert property (
		xbe && a0_q[5:0] == 6'h00 && a1_q[1:0] == 2'h0 |=>
		pin_oe == ($past(im_q) & ($past(om_q) | ~$past(lt_q))) &&
		(pin_out & pin_oe) == ($past(im_q) & $past(om_q) & $past(lt_q)))
		else $error("latch drive wrong");
	a_analog_copy: assert property (
		presetn |=> analog_in == $past(pin_in)) else $error("analog copy");
endmodule
bind ppcx_top ppcx_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .pslverr(pslverr), .periph_in(periph_in),
	.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
	.pin_pullup(pin_pullup), .analog_in(analog_in), .port_in(port_in));

// File: bench/ppcx_pin_model.sv
// pad level model: drivers, weak pullups, wandering undriven level
`timescale 1ns/100ps
module ppcx_pin_model
(
	// design drive
	input logic pclk,
	input logic [15:0] pin_out,
	input logic [15:0] pin_oe,
	input logic [15:0] pin_pullup,
	// pad level
	output logic [15:0] pad
);
	logic [15:0] float_q = 16'ha5a5;
	// a floating pad must not look like a held level
	always @(posedge pclk)
		float_q <= ~float_q;
	// driver first, then pullup, then the wandering level
	assign pad = (pin_oe & pin_out) | (~pin_oe & (pin_pullup | float_q));
endmodule

// File: bench/port_pin_config_crossbar_tb.sv
// self-checking bench for the port pin crossbar
`timescale 1ns/100ps
module port_pin_config_crossbar_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, ev;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rv;
	logic [7:0] periph_out = 8'h00, periph_oe = 8'h00, periph_in;
	logic [15:0] pin_in, pin_out, pin_oe, pin_pullup, analog_in, port_in;
	int fails = 0, check_count = 0;
	// 100 MHz clock
	always #5 pclk = ~pclk;
	ppcx_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.periph_out(periph_out), .periph_oe(periph_oe),
		.periph_in(periph_in), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_pullup(pin_pullup), .analog_in(analog_in),
		.port_in(port_in));
	ppcx_pin_model pads_u (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pullup), .pad(pin_in));
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// one transfer, held until pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never sees pready
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input string n, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(n, e, rv);
	endtask
	// let registered outputs land, sample mid-cycle
	task settle;
		repeat (3) @(posedge pclk);
		@(negedge pclk);
	endtask
	task t_reset;
		apb(1'b1, 12'h040, 32'h0000_0000);
		chk("unmapped err", 32'h1, 32'(ev));
		rd("input mode", 12'h000, 32'h0000_ffff);
		rd("assign 1", 12'h014, 32'h0000_0000);
		settle;
		chk("oe reset", 32'h0, 32'(pin_oe));
	endtask
	task t_route;
		apb(1'b1, 12'h000, 32'h0000_fff0);
		apb(1'b1, 12'h004, 32'h0000_5a5f);
		apb(1'b1, 12'h008, 32'h0000_00f0);
		apb(1'b1, 12'h00c, 32'h0000_000f);
		apb(1'b1, 12'h010, 32'h0000_0007);
		apb(1'b1, 12'h014, 32'h0000_0040);
		rd("taken", 12'h01c, 32'h0000_0070);
		@(posedge pclk);
		periph_oe <= 8'h07;
		periph_out <= 8'h07;
		settle;
		chk("bus release", 32'h0, 32'(pin_oe[5:4]));
		chk("pp drive", 32'h1, 32'(pin_oe[6] & pin_out[6]));
		chk("bus in high", 32'h3, 32'(periph_in[1:0]));
		@(posedge pclk);
		periph_out <= 8'h04;
		settle;
		chk("bus low", 32'h30, 32'(pin_oe & ~pin_out & 16'h0030));
		chk("pullup low", 32'h0, 32'(pin_pullup[5:4]));
		chk("bus in low", 32'h0, 32'(periph_in[1:0]));
	endtask
	task t_plain;
		apb(1'b1, 12'h010, 32'h0000_0000);
		apb(1'b1, 12'h014, 32'h0000_00c0);
		settle;
		chk("latch oe", 32'ha5f0, 32'(pin_oe));
		chk("latch out", 32'h0050, 32'(pin_out & pin_oe));
		chk("pullup off", 32'h0, 32'(pin_pullup));
	endtask
	task t_off;
		apb(1'b1, 12'h014, 32'h0000_0000);
		settle;
		chk("oe off", 32'h0, 32'(pin_oe));
		chk("periph off", 32'h0, 32'(periph_in));
		chk("analog recv", 32'h0, 32'(port_in[3:0]));
		chk("pullup od", 32'hff00, 32'(pin_pullup & 16'hff0f));
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd("mode again", 12'h000, 32'h0000_ffff);
	endtask
	task report_and_stop;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_route;
		t_plain;
		t_off;
		report_and_stop;
	end
	// hang guard, well past the expected run
	initial
	begin
		repeat (3000) @(posedge pclk);
		fails++;
		report_and_stop;
	end
endmodule
